// ===== src/act_regs.vh
// Register map, field layout and constants of the converter control block
`ifndef ACT_REGS_VH
`define ACT_REGS_VH

`define ACT_ADDR_W        4
`define ACT_DATA_W        8

`define ACT_OFF_SC1       4'h0
`define ACT_OFF_SC2       4'h1
`define ACT_OFF_CFG       4'h2
`define ACT_OFF_RESH      4'h3
`define ACT_OFF_RESL      4'h4
`define ACT_OFF_APCL      4'h5
`define ACT_OFF_APCH      4'h6
`define ACT_OFF_ISTS      4'h7
`define ACT_OFF_IMSK      4'h8

`define ACT_SC1_CHAN_LSB  0
`define ACT_SC1_CONT_BIT  5
`define ACT_SC1_COCO_BIT  7
`define ACT_SC2_HWT_BIT   0
`define ACT_SC2_BUSY_BIT  7
`define ACT_CFG_MODE_BIT  2
`define ACT_CFG_DIV_LSB   5

`define ACT_IRQ_DONE      0
`define ACT_IRQ_IGN       1
`define ACT_IRQ_ABORT     2

`define ACT_CHAN_RST      5'h1f
`define ACT_CHAN_OFF      5'h1f
`define ACT_CHAN_LOW_LO   5'h10
`define ACT_CHAN_LOW_HI   5'h15
`define ACT_CHAN_TEMP     5'h1a
`define ACT_CHAN_GAP      5'h1b
`define ACT_CHAN_HIGH     5'h1d
`define ACT_CHAN_LOW      5'h1e

`endif

// ===== src/act_ctrl.v
// Channel, trigger, divider and pin control for the 10-bit converter
`timescale 1ns/10ps
`default_nettype none
`include "act_regs.vh"

module act_ctrl (
    input  wire        clk,
    input  wire        nrst,
    input  wire [3:0]  bus_addr,
    input  wire [7:0]  bus_wdata,
    input  wire        bus_wr,
    input  wire        bus_rd,
    output wire [7:0]  bus_rdata,
    input  wire        hw_trigger_input,
    output wire        core_start,
    output wire        core_abort,
    output wire [4:0]  core_channel,
    output wire        core_to_low_ref,
    output wire        core_enable,
    output wire        core_mode_10,
    output wire        core_clk_en,
    input  wire        core_done,
    input  wire [9:0]  core_result,
    input  wire [15:0] port_out,
    input  wire [15:0] port_oe,
    input  wire [15:0] port_pull,
    input  wire [15:0] pad_in,
    output wire [15:0] pad_out,
    output wire [15:0] pad_oe,
    output wire [15:0] pad_pull_en,
    output wire [15:0] port_in,
    output wire        irq
);

    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_CONV = 2'b10;

    // Unused and reserved codes still reach the core; they read back garbage
    function low_ref;
        input [4:0] code;
        begin
            low_ref = ((code >= `ACT_CHAN_LOW_LO) && (code <= `ACT_CHAN_LOW_HI))
                      || (code == `ACT_CHAN_LOW);
        end
    endfunction

    function [2:0] div_top;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    div_top = 3'h0;
                2'h1:    div_top = 3'h1;
                2'h2:    div_top = 3'h3;
                default: div_top = 3'h7;
            endcase
        end
    endfunction

    function chan_off;
        input [4:0] code;
        begin
            chan_off = (code == `ACT_CHAN_OFF);
        end
    endfunction

    // Analog pins drop every digital request, whatever the port asks
    function [15:0] mask_analog;
        input [15:0] req;
        input [15:0] sel;
        begin
            mask_analog = req & ~sel;
        end
    endfunction

    reg [1:0]  state_reg;
    reg [1:0]  state_next;
    reg [4:0]  chan_reg;
    reg [4:0]  chan_next;
    reg        cont_reg;
    reg        hwt_reg;
    reg        mode_reg;
    reg [1:0]  div_reg;
    reg [7:0]  apcl_reg;
    reg [7:0]  apch_reg;
    reg [9:0]  res_reg;
    reg        coco_reg;
    reg [2:0]  ists_reg;
    reg [2:0]  ists_next;
    reg [2:0]  imsk_reg;
    reg        irq_reg;
    reg [7:0]  rdata_reg;
    reg [7:0]  rdata_next;
    reg        start_reg;
    reg        abort_reg;
    reg        lowref_reg;
    reg        enable_reg;
    reg [2:0]  cnt_reg;
    reg        clken_reg;
    reg        trg_s1;
    reg        trg_s2;
    reg        trg_s3;
    reg [15:0] pad_s1;
    reg [15:0] pad_s2;
    reg [15:0] pad_out_reg;
    reg [15:0] pad_oe_reg;
    reg [15:0] pull_reg;
    reg [15:0] port_in_reg;

    wire        busy;
    wire        wr_sc1;
    wire        sw_start;
    wire        hw_edge;
    wire        hw_start;
    wire        hw_ignored;
    wire        done;
    wire        restart;
    wire [15:0] analog;
    wire        rd_ists;
    wire        rd_resl;

    assign busy       = state_reg[1];
    assign wr_sc1     = bus_wr && (bus_addr == `ACT_OFF_SC1);
    assign sw_start   = wr_sc1 && !hwt_reg
                        && !chan_off(bus_wdata[4:0]);
    assign hw_edge    = trg_s2 && !trg_s3;
    // Busy covers a continuous run, so later edges fall here too
    assign hw_start   = hw_edge && hwt_reg && !busy && !wr_sc1
                        && !chan_off(chan_reg);
    assign hw_ignored = hw_edge && hwt_reg && busy;
    assign done       = busy && core_done && !wr_sc1;
    assign restart    = done && cont_reg;
    assign analog     = {apch_reg, apcl_reg};
    assign rd_ists    = bus_rd && (bus_addr == `ACT_OFF_ISTS);
    assign rd_resl    = bus_rd && (bus_addr == `ACT_OFF_RESL);

    always @* begin
        chan_next = chan_reg;
        if (wr_sc1) begin
            chan_next = bus_wdata[4:0];
        end
    end

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (sw_start || hw_start) begin
                    state_next = ST_CONV;
                end
            end
            ST_CONV: begin
                if (wr_sc1) begin
                    // New settings act at once after the abort
                    state_next = sw_start ? ST_CONV : ST_IDLE;
                end else if (done && !cont_reg) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @* begin
        ists_next = ists_reg;
        if (rd_ists) begin
            ists_next = 3'h0;
        end
        // Events set after the read clear, so none is lost
        if (done) begin
            ists_next[`ACT_IRQ_DONE] = 1'b1;
        end
        if (hw_ignored) begin
            ists_next[`ACT_IRQ_IGN] = 1'b1;
        end
        if (wr_sc1 && busy) begin
            ists_next[`ACT_IRQ_ABORT] = 1'b1;
        end
    end

    always @* begin
        rdata_next = 8'h00;
        case (bus_addr)
            `ACT_OFF_SC1: begin
                rdata_next[4:0] = chan_reg;
                rdata_next[`ACT_SC1_CONT_BIT] = cont_reg;
                rdata_next[`ACT_SC1_COCO_BIT] = coco_reg;
            end
            `ACT_OFF_SC2: begin
                rdata_next[`ACT_SC2_HWT_BIT] = hwt_reg;
                rdata_next[`ACT_SC2_BUSY_BIT] = busy;
            end
            `ACT_OFF_CFG: begin
                rdata_next[`ACT_CFG_MODE_BIT] = mode_reg;
                rdata_next[`ACT_CFG_DIV_LSB +: 2] = div_reg;
            end
            `ACT_OFF_RESH: begin
                rdata_next[1:0] = res_reg[9:8];
            end
            `ACT_OFF_RESL: begin
                rdata_next = res_reg[7:0];
            end
            `ACT_OFF_APCL: begin
                rdata_next = apcl_reg;
            end
            `ACT_OFF_APCH: begin
                rdata_next = apch_reg;
            end
            `ACT_OFF_ISTS: begin
                rdata_next[2:0] = ists_reg;
            end
            `ACT_OFF_IMSK: begin
                rdata_next[2:0] = imsk_reg;
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            chan_reg  <= `ACT_CHAN_RST;
            cont_reg  <= 1'b0;
            hwt_reg   <= 1'b0;
            mode_reg  <= 1'b0;
            div_reg   <= 2'h0;
            apcl_reg  <= 8'h00;
            apch_reg  <= 8'h00;
            imsk_reg  <= 3'h0;
            ists_reg  <= 3'h0;
            irq_reg   <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            chan_reg  <= chan_next;
            ists_reg  <= ists_next;
            irq_reg   <= |(ists_next & imsk_reg);
            if (bus_rd) begin
                rdata_reg <= rdata_next;
            end else begin
                rdata_reg <= 8'h00;
            end
            if (wr_sc1) begin
                cont_reg <= bus_wdata[`ACT_SC1_CONT_BIT];
            end
            if (bus_wr) begin
                case (bus_addr)
                    `ACT_OFF_SC2: begin
                        hwt_reg <= bus_wdata[`ACT_SC2_HWT_BIT];
                    end
                    `ACT_OFF_CFG: begin
                        mode_reg <= bus_wdata[`ACT_CFG_MODE_BIT];
                        div_reg  <= bus_wdata[`ACT_CFG_DIV_LSB +: 2];
                    end
                    `ACT_OFF_APCL: begin
                        apcl_reg <= bus_wdata;
                    end
                    `ACT_OFF_APCH: begin
                        apch_reg <= bus_wdata;
                    end
                    `ACT_OFF_IMSK: begin
                        imsk_reg <= bus_wdata[2:0];
                    end
                    default: begin
                        imsk_reg <= imsk_reg;
                    end
                endcase
            end
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            res_reg  <= 10'h000;
            coco_reg <= 1'b0;
        end else begin
            if (done) begin
                // Eight-bit results keep the upper bits clear
                if (mode_reg) begin
                    res_reg <= core_result;
                end else begin
                    res_reg <= {2'b00, core_result[7:0]};
                end
                coco_reg <= 1'b1;
            end else if (wr_sc1 || rd_resl) begin
                coco_reg <= 1'b0;
            end
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            start_reg  <= 1'b0;
            abort_reg  <= 1'b0;
            lowref_reg <= 1'b0;
            enable_reg <= 1'b0;
        end else begin
            start_reg  <= sw_start || hw_start || restart;
            abort_reg  <= wr_sc1 && busy;
            lowref_reg <= low_ref(chan_next);
            enable_reg <= !chan_off(chan_next);
        end
    end

    // Divider only runs while converting, to save power when idle
    always @(posedge clk) begin
        if (!nrst) begin
            cnt_reg   <= 3'h0;
            clken_reg <= 1'b0;
        end else if (!busy) begin
            cnt_reg   <= 3'h0;
            clken_reg <= 1'b0;
        end else if (cnt_reg >= div_top(div_reg)) begin
            cnt_reg   <= 3'h0;
            clken_reg <= 1'b1;
        end else begin
            cnt_reg   <= cnt_reg + 3'h1;
            clken_reg <= 1'b0;
        end
    end

    // Trigger is asynchronous: two stages, then the edge stage
    always @(posedge clk) begin
        if (!nrst) begin
            trg_s1 <= 1'b0;
            trg_s2 <= 1'b0;
            trg_s3 <= 1'b0;
        end else begin
            trg_s1 <= hw_trigger_input;
            trg_s2 <= trg_s1;
            trg_s3 <= trg_s2;
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            pad_s1      <= 16'h0000;
            pad_s2      <= 16'h0000;
            pad_out_reg <= 16'h0000;
            pad_oe_reg  <= 16'h0000;
            pull_reg    <= 16'h0000;
            port_in_reg <= 16'h0000;
        end else begin
            pad_s1      <= pad_in;
            pad_s2      <= pad_s1;
            pad_out_reg <= mask_analog(port_out, analog);
            pad_oe_reg  <= mask_analog(port_oe, analog);
            pull_reg    <= mask_analog(port_pull, analog);
            port_in_reg <= mask_analog(pad_s2, analog);
        end
    end

    assign bus_rdata       = rdata_reg;
    assign core_start      = start_reg;
    assign core_abort      = abort_reg;
    assign core_channel    = chan_reg;
    assign core_to_low_ref = lowref_reg;
    assign core_enable     = enable_reg;
    assign core_mode_10    = mode_reg;
    assign core_clk_en     = clken_reg;
    assign pad_out         = pad_out_reg;
    assign pad_oe          = pad_oe_reg;
    assign pad_pull_en     = pull_reg;
    assign port_in         = port_in_reg;
    assign irq             = irq_reg;

endmodule // act_ctrl

`default_nettype wire

// ===== verification/act_ctrl_checker.sv
// Port-level assertions for the converter control block
`timescale 1ns/10ps
`default_nettype none
module act_ctrl_checker (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [3:0]  bus_addr,
    input wire logic [7:0]  bus_wdata,
    input wire logic        bus_wr,
    input wire logic        core_start,
    input wire logic [4:0]  core_channel,
    input wire logic        core_to_low_ref,
    input wire logic        core_enable,
    input wire logic        core_mode_10,
    input wire logic [15:0] port_oe,
    input wire logic [15:0] port_pull,
    input wire logic [15:0] pad_oe,
    input wire logic [15:0] pad_pull_en,
    input wire logic [15:0] port_in
);
    logic [15:0] an_reg;
    logic        hwe_reg;

    // Shadows of bus-written settings (analog select, trigger select) that the ports do not show
    always_ff @(posedge clk) begin
        if (!nrst) begin
            an_reg  <= 16'h0000;
            hwe_reg <= 1'b0;
        end else if (bus_wr && bus_addr == 4'h5) begin
            an_reg[7:0] <= bus_wdata;
        end else if (bus_wr && bus_addr == 4'h6) begin
            an_reg[15:8] <= bus_wdata;
        end else if (bus_wr && bus_addr == 4'h1) begin
            hwe_reg <= bus_wdata[0];
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence ctl_write;
        bus_wr && bus_addr == 4'h0;
    endsequence
    sequence sw_write;
        ctl_write ##0 (bus_wdata[4:0] != 5'h1f && !hwe_reg);
    endsequence

    chan_follow_a: assert property (ctl_write |=> core_channel == $past(bus_wdata[4:0]))
        else $error("channel output does not follow control write");
    low_ref_a: assert property (core_to_low_ref == ((core_channel >= 5'h10
        && core_channel <= 5'h15) || core_channel == 5'h1e))
        else $error("low reference select wrong for channel");
    chan_off_a: assert property (ctl_write ##0 bus_wdata[4:0] == 5'h1f
        |=> !core_start && !core_enable)
        else $error("disabled channel code started or enabled the core");
    enable_a: assert property (core_enable == (core_channel != 5'h1f))
        else $error("core enable disagrees with channel code");
    oe_mask_a: assert property ($past(nrst) |-> pad_oe == $past(port_oe & ~an_reg))
        else $error("output enable not masked by analog select");
    in_zero_a: assert property ((port_in & $past(an_reg)) == 16'h0000)
        else $error("analog pin reads nonzero");
    pull_mask_a: assert property ($past(nrst) |-> pad_pull_en == $past(port_pull & ~an_reg))
        else $error("pull-up not masked by analog select");
    mode_sel_a: assert property (bus_wr && bus_addr == 4'h2
        |=> core_mode_10 == $past(bus_wdata[2]))
        else $error("resolution output does not follow mode bit");
    sw_start_a: assert property (sw_write |=> core_start)
        else $error("software write did not start a conversion");
endmodule // act_ctrl_checker
`default_nettype wire

// ===== verification/act_core_model.sv
// Behavioural analog converter core: counts clock ticks, then reports
`timescale 1ns/10ps
`default_nettype none
module act_core_model #(
    parameter int TICKS = 20
) (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       core_start,
    input wire logic       core_abort,
    input wire logic [4:0] core_channel,
    input wire logic       core_to_low_ref,
    input wire logic       core_clk_en,
    output var logic       core_done,
    output var logic [9:0] core_result
);
    int   cnt;
    logic run;

    always @(posedge clk) begin
        core_done   <= 1'b0;
        // Result lines toggle outside the done pulse so stale data shows
        core_result <= ~core_result;
        if (!nrst) begin
            run         <= 1'b0;
            cnt         <= 0;
            core_result <= 10'h000;
        end else if (core_start) begin
            run <= 1'b1;
            cnt <= 0;
        end else if (core_abort) begin
            run <= 1'b0;
        end else if (run && core_clk_en) begin
            cnt <= cnt + 1;
            if (cnt == TICKS - 1) begin
                run         <= 1'b0;
                core_done   <= 1'b1;
                core_result <= core_to_low_ref ? 10'h000 : {core_channel, 5'h0b};
            end
        end
    end
endmodule // act_core_model
`default_nettype wire

// ===== verification/test_act_ctrl.sv
// Directed bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module test_act_ctrl;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [3:0]  bus_addr = 4'h0;
    logic [7:0]  bus_wdata = 8'h00;
    logic        bus_wr = 1'b0;
    logic        bus_rd = 1'b0;
    logic        hw_trigger_input = 1'b0;
    logic [15:0] port_out = 16'hffff;
    logic [15:0] port_oe = 16'hffff;
    logic [15:0] port_pull = 16'hffff;
    logic [15:0] pad_in = 16'hffff;
    logic [7:0]  bus_rdata;
    logic [4:0]  core_channel;
    logic [9:0]  core_result;
    logic        core_start, core_abort, core_to_low_ref, core_enable;
    logic        core_mode_10, core_clk_en, core_done, irq;
    logic [15:0] pad_out, pad_oe, pad_pull_en, port_in;
    int          err_count = 0;
    int          num_checks = 0;
    int          n;
    int          cnt;

    always #12.5 clk = ~clk;

    act_ctrl i_dut (
        .clk              (clk),
        .nrst             (nrst),
        .bus_addr         (bus_addr),
        .bus_wdata        (bus_wdata),
        .bus_wr           (bus_wr),
        .bus_rd           (bus_rd),
        .bus_rdata        (bus_rdata),
        .hw_trigger_input (hw_trigger_input),
        .core_start       (core_start),
        .core_abort       (core_abort),
        .core_channel     (core_channel),
        .core_to_low_ref  (core_to_low_ref),
        .core_enable      (core_enable),
        .core_mode_10     (core_mode_10),
        .core_clk_en      (core_clk_en),
        .core_done        (core_done),
        .core_result      (core_result),
        .port_out         (port_out),
        .port_oe          (port_oe),
        .port_pull        (port_pull),
        .pad_in           (pad_in),
        .pad_out          (pad_out),
        .pad_oe           (pad_oe),
        .pad_pull_en      (pad_pull_en),
        .port_in          (port_in),
        .irq              (irq)
    );

    act_core_model i_core (
        .clk             (clk),
        .nrst            (nrst),
        .core_start      (core_start),
        .core_abort      (core_abort),
        .core_channel    (core_channel),
        .core_to_low_ref (core_to_low_ref),
        .core_clk_en     (core_clk_en),
        .core_done       (core_done),
        .core_result     (core_result)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        chk({8'h00, bus_rdata}, {8'h00, exp});
    endtask

    // Bounded wait for a start (sel 0) or done (sel 1) pulse
    task automatic wait_ev(input int sel);
        n = 0;
        while ((sel ? core_done : core_start) !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        if ((sel ? core_done : core_start) !== 1'b1) chk(16'h0000, 16'h0001);
    endtask

    task automatic print_verdict();
        if (err_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge clk);
        err_count++;
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd(4'h0, 8'h1f);
        rd(4'hf, 8'h00);
        wr(4'h8, 8'h07);
        wr(4'h2, 8'h04);
        wr(4'h0, 8'h0d);
        chk({15'h0, core_start}, 16'h0001);
        wait_ev(1);
        rd(4'h0, 8'h8d);
        rd(4'h3, 8'h01);
        rd(4'h4, 8'hab);
        chk({15'h0, irq}, 16'h0001);
        rd(4'h7, 8'h01);
        @(posedge clk);
        #1;
        chk({15'h0, irq}, 16'h0000);
        // Eight-bit sensor conversion with the interrupt masked
        wr(4'h8, 8'h00);
        wr(4'h2, 8'h00);
        wr(4'h0, 8'h1a);
        wait_ev(1);
        rd(4'h3, 8'h00);
        rd(4'h4, 8'h4b);
        chk({15'h0, irq}, 16'h0000);
        wr(4'h8, 8'h01);
        @(posedge clk);
        #1;
        chk({15'h0, irq}, 16'h0001);
        for (int d = 0; d < 4; d++) begin
            wr(4'h2, 8'(d << 5));
            wr(4'h0, 8'h01);
            cnt = 0;
            repeat (16) begin
                @(posedge clk);
                #1;
                cnt += int'(core_clk_en);
            end
            chk(cnt[15:0], 16'(16 >> d));
            wait_ev(1);
        end
        rd(4'h7, 8'h01);
        // Continuous hardware run on a low-reference code, second edge ignored
        wr(4'h2, 8'h04);
        wr(4'h1, 8'h01);
        wr(4'h0, 8'h32);
        chk({15'h0, core_start}, 16'h0000);
        @(posedge clk);
        hw_trigger_input <= 1'b1;
        wait_ev(0);
        @(posedge clk);
        hw_trigger_input <= 1'b0;
        repeat (3) @(posedge clk);
        hw_trigger_input <= 1'b1;
        wait_ev(1);
        rd(4'h4, 8'h00);
        rd(4'h7, 8'h03);
        @(posedge clk);
        hw_trigger_input <= 1'b0;
        // Continuous software conversions, then an abort
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h24);
        wait_ev(1);
        @(posedge clk);
        #1;
        chk({15'h0, core_start}, 16'h0001);
        wr(4'h0, 8'h1f);
        chk({15'h0, core_abort}, 16'h0001);
        rd(4'h7, 8'h05);
        wr(4'h5, 8'h0f);
        wr(4'h6, 8'h80);
        repeat (4) @(posedge clk);
        #1;
        chk(pad_oe, 16'h7ff0);
        chk(pad_out, 16'h7ff0);
        chk(port_in, 16'h7ff0);
        chk(pad_pull_en, 16'h7ff0);
        print_verdict();
    end
endmodule // test_act_ctrl

bind act_ctrl act_ctrl_checker i_chk (
    .clk             (clk),
    .nrst            (nrst),
    .bus_addr        (bus_addr),
    .bus_wdata       (bus_wdata),
    .bus_wr          (bus_wr),
    .core_start      (core_start),
    .core_channel    (core_channel),
    .core_to_low_ref (core_to_low_ref),
    .core_enable     (core_enable),
    .core_mode_10    (core_mode_10),
    .port_oe         (port_oe),
    .port_pull       (port_pull),
    .pad_oe          (pad_oe),
    .pad_pull_en     (pad_pull_en),
    .port_in         (port_in)
);
`default_nettype wire
